// ===== dv/crx_frame_src.sv
// Behavioural protocol engine that presents received identifiers to the filter.
`timescale 1ns/1ps
module crx_frame_src
  import crx_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  // Frame request from the bench
  input  wire logic              req_i,
  input  wire crx_pkg::crx_sid_t sid_i,
  input  wire crx_pkg::crx_eid_t eid_i,
  input  wire logic              ide_i,
  // Identifier lines towards the filter
  output logic                   frm_valid_o,
  output crx_pkg::crx_sid_t      frm_sid_o,
  output crx_pkg::crx_eid_t      frm_eid_o,
  output logic                   frm_ide_o
);
  crx_sid_t sid_d;
  crx_eid_t eid_d;
  logic     ide_d;

  // Between frames the lines flip every cycle, so stale data can never pass for a frame.
  always_comb begin
    sid_d = req_i ? sid_i : ~frm_sid_o;
    eid_d = req_i ? eid_i : ~frm_eid_o;
    ide_d = req_i ? ide_i : ~frm_ide_o;
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      {frm_valid_o, frm_sid_o, frm_eid_o, frm_ide_o} <= '0;
    end else begin
      {frm_valid_o, frm_sid_o, frm_eid_o, frm_ide_o} <= {req_i, sid_d, eid_d, ide_d};
    end
  end
endmodule : crx_frame_src

// ===== dv/crx_top_assertions.sv
// Port-level checks of the acceptance filter, bound to its top module.
`timescale 1ns/1ps
`include "crx_consts.svh"
module crx_top_chk
  import crx_pkg::*;
(
  // Clock, reset and register bus
  input wire logic              clk_sys_i,
  input wire logic              rst_i,
  input wire logic              hsel_i,
  input wire logic [31:0]       haddr_i,
  input wire logic [1:0]        htrans_i,
  input wire logic              hwrite_i,
  input wire logic [2:0]        hsize_i,
  input wire logic [31:0]       hwdata_i,
  input wire logic              hready_i,
  // Frame, filter values and result
  input wire logic              frm_valid_i,
  input wire crx_pkg::crx_sid_t frm_sid_i,
  input wire crx_pkg::crx_eid_t frm_eid_i,
  input wire logic              frm_ide_i,
  input wire logic [3:0]        flt_en_i,
  input wire logic [43:0]       flt_sid_i,
  input wire logic [71:0]       flt_eid_i,
  input wire logic [3:0]        flt_filter_extended_frame_select_i,
  input wire logic              acc_valid_o,
  input wire logic              acc_hit_o,
  input wire crx_pkg::crx_buf_t acc_filter_o,
  input wire crx_pkg::crx_buf_t acc_buffer_o
);
  logic        wp_q, wp_d, exp_hit;
  logic [7:0]  wa_q;
  crx_reg_t    bp_q, bp_d, sm_q, sm_d, em_q, em_d;
  logic [28:0] care, diff;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // Register shadow; a write lands at the end of its data phase, as in the slave.
  always_comb begin
    wp_d = hsel_i && htrans_i[1] && hready_i && hwrite_i && hsize_i == `CRX_HSIZE_WORD;
    bp_d = (wp_q && wa_q == `CRX_OFS_BUFPTR) ? hwdata_i[15:0] : bp_q;
    sm_d = (wp_q && wa_q == `CRX_OFS_MASK_SID) ? hwdata_i[15:0] & 16'hFFEB : sm_q;
    em_d = (wp_q && wa_q == `CRX_OFS_MASK_EID) ? hwdata_i[15:0] : em_q;
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      {wp_q, wa_q, bp_q, sm_q, em_q} <= '0;
    end else begin
      {wp_q, wa_q, bp_q, sm_q, em_q} <= {wp_d, haddr_i[7:0], bp_d, sm_d, em_d};
    end
  end
  // Expected hit of filter 12; trusted only while it is the sole enabled filter.
  always_comb begin
    care = {sm_q[15:5], frm_ide_i ? {sm_q[1:0], em_q} : 18'h00000};
    diff = {frm_sid_i ^ flt_sid_i[10:0], frm_eid_i ^ flt_eid_i[17:0]};
    exp_hit = (diff & care) == 29'h0 && !(sm_q[3] && frm_ide_i != flt_filter_extended_frame_select_i[0]);
  end

  chk_valid_next: assert property (frm_valid_i |=> acc_valid_o)
    else $error("result missing one cycle after a frame");
  chk_valid_only: assert property (!frm_valid_i |=> !acc_valid_o)
    else $error("result without a frame");
  chk_single_flt: assert property (frm_valid_i && flt_en_i == 4'h1 |=> acc_hit_o == $past(exp_hit))
    else $error("masked compare of filter 12 wrong");
  chk_type_mode: assert property (frm_valid_i && sm_q[3] && frm_ide_i != flt_filter_extended_frame_select_i[3]
    && flt_en_i == 4'h8 |=> !acc_hit_o) else $error("frame type mismatch accepted");
  chk_open_mask: assert property (frm_valid_i && sm_q == 16'h0000 && em_q == 16'h0000
    && flt_en_i != 4'h0 |=> acc_hit_o && acc_filter_o >= 4'hC) else $error("open mask missed");
  chk_route_ptr: assert property (acc_valid_o && acc_hit_o |->
    acc_buffer_o == crx_buf_t'($past(bp_q) >> {acc_filter_o[1:0], 2'b00})) else $error("bad buffer");
  chk_miss_clear: assert property (acc_valid_o && !acc_hit_o |->
    acc_filter_o == 4'h0 && acc_buffer_o == 4'h0) else $error("miss carries a route");
  chk_hold_route: assert property (!frm_valid_i |=> $stable(acc_buffer_o)
    && $stable(acc_filter_o)) else $error("route changed without a frame");
endmodule : crx_top_chk

bind crx_top crx_top_chk i_crx_top_chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
  .hready_i(hready_i), .frm_valid_i(frm_valid_i), .frm_sid_i(frm_sid_i),
  .frm_eid_i(frm_eid_i), .frm_ide_i(frm_ide_i), .flt_en_i(flt_en_i), .flt_sid_i(flt_sid_i),
  .flt_eid_i(flt_eid_i), .flt_filter_extended_frame_select_i(flt_filter_extended_frame_select_i), .acc_valid_o(acc_valid_o),
  .acc_hit_o(acc_hit_o), .acc_filter_o(acc_filter_o), .acc_buffer_o(acc_buffer_o));

// ===== dv/crx_top_tb.sv
// Self-checking bench for the acceptance filter and its register slave.
`timescale 1ns/1ps
`include "crx_consts.svh"
`define CHK(nm, ex, got) begin \
  check_count++; \
  if ((got) !== (ex)) begin \
    num_errors++; \
    $display("BAD %s exp %0h got %0h", nm, ex, got); \
  end \
end
module crx_top_tb;
  import crx_pkg::*;
  logic        clk, rst, hsel, hwrite, hready, hresp, req, r_ide, fv, fide, av, ah;
  logic [1:0]  htrans;
  logic [2:0]  hsize, sz;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [3:0]  fen, fexi;
  logic [43:0] fsidv;
  logic [71:0] feidv;
  logic [95:0] rv;
  crx_sid_t    r_sid, fsid;
  crx_eid_t    r_eid, feid;
  crx_buf_t    af, ab;
  crx_reg_t    m_bp, m_sm, m_em, last_st;
  int          num_errors, check_count, e, h, f, b, k, i, rnd;
  int          exq[$];

  crx_top i_crx_top (
    .clk_sys_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .frm_valid_i(fv),
    .frm_sid_i(fsid), .frm_eid_i(feid), .frm_ide_i(fide), .flt_en_i(fen),
    .flt_sid_i(fsidv), .flt_eid_i(feidv), .flt_filter_extended_frame_select_i(fexi), .acc_valid_o(av),
    .acc_hit_o(ah), .acc_filter_o(af), .acc_buffer_o(ab));
  crx_frame_src i_crx_frame_src (
    .clk_sys_i(clk), .rst_i(rst), .req_i(req), .sid_i(r_sid), .eid_i(r_eid), .ide_i(r_ide),
    .frm_valid_o(fv), .frm_sid_o(fsid), .frm_eid_o(feid), .frm_ide_o(fide));

  // Free-running 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Single place where the run ends.
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  // One transfer of size sz; each phase is held until ready is seen high at an edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    hsize <= sz;
    for (int p = 0; p < 2; p++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (hready !== 1'b1 && n < 64);
      num_errors += int'(hready !== 1'b1);
      if (hready !== 1'b1) close_out();
      // Release only after the address phase, so a following call may drive at once.
      if (p == 0) begin
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
      end
    end
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask : bus

  // Writes also update the bench copy; reserved mask bits always read back as zero.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    if (a == `CRX_OFS_BUFPTR) m_bp = d[15:0];
    if (a == `CRX_OFS_MASK_SID) m_sm = d[15:0] & 16'hFFEB;
    if (a == `CRX_OFS_MASK_EID) m_em = d[15:0];
  endtask : wr

  task automatic rdc(input logic [7:0] a, input crx_reg_t ex);
    bus(1'b0, a, 32'h00000000);
    `CHK("rdata", {16'h0000, ex}, rd)
  endtask : rdc

  // Reference acceptance; the lowest hitting filter wins, so it is visited last.
  function automatic void predict();
    logic [28:0] c, d;
    h = 0;
    f = 0;
    b = 0;
    c = {m_sm[15:5], fide ? {m_sm[1:0], m_em} : 18'h00000};
    for (int j = 3; j >= 0; j--) begin
      d = {fsid ^ fsidv[j*11 +: 11], feid ^ feidv[j*18 +: 18]};
      if (fen[j] && (c & d) == 0 && !(m_sm[3] && fide != fexi[j])) begin
        h = 1;
        f = 12 + j;
        b = m_bp[j*4 +: 4];
      end
    end
    last_st = {4'h0, f[3:0], b[3:0], 2'b00, fide, h[0]};
  endfunction : predict

  // Sample half a cycle after each edge so every register update has landed.
  always @(negedge clk) begin
    if (av !== 1'b0) begin
      e = (exq.size() > 0) ? exq.pop_front() : -1;
      `CHK("acc", e[8:0], {ah, af, ab})
    end
    if (fv === 1'b1 && rst === 1'b0) begin
      predict();
      exq.push_back(h * 256 + f * 16 + b);
    end
  end

  // Hard stop in case the sequence hangs.
  initial begin
    repeat (50000) @(posedge clk);
    num_errors++;
    close_out();
  end

  initial begin
    {rst, hsel, hwrite, req, r_ide} = 5'h10;
    {htrans, hsize, haddr, hwdata, fen, fexi, fsidv, feidv, r_sid, r_eid} = '0;
    {m_bp, m_sm, m_em, last_st} = '0;
    sz = `CRX_HSIZE_WORD;
    void'($urandom(32'h6a62496c));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(8'h10, 16'h0000);
    // A write narrower than a word must leave the register untouched.
    sz = 3'h0;
    bus(1'b1, `CRX_OFS_MASK_EID, 32'h0000FFFF);
    sz = `CRX_HSIZE_WORD;
    rdc(`CRX_OFS_MASK_EID, 16'h0000);
    // Round zero runs on reset masks, so every enabled filter accepts any frame.
    for (rnd = 0; rnd < 24; rnd++) begin
      if (rnd > 0) begin
        wr(`CRX_OFS_BUFPTR, $urandom);
        wr(`CRX_OFS_MASK_SID, $urandom & $urandom);
        wr(`CRX_OFS_MASK_EID, $urandom & $urandom);
        wr(8'h14, $urandom);
      end
      rdc(`CRX_OFS_BUFPTR, m_bp);
      rdc(`CRX_OFS_MASK_SID, m_sm);
      rdc(`CRX_OFS_MASK_EID, m_em);
      rv = {$urandom, $urandom, $urandom};
      fsidv <= rv[95:52];
      feidv <= rv[71:0];
      fen <= 4'($urandom);
      fexi <= 4'($urandom);
      @(posedge clk);
      // Back-to-back frames, a quarter of them exact copies of one filter's value.
      for (i = 0; i < 12; i++) begin
        k = $urandom_range(3);
        rv = {$urandom, $urandom, $urandom};
        req <= 1'b1;
        r_ide <= rv[0];
        r_sid <= fsidv[k*11 +: 11] ^ (rv[1] ? 11'h000 : rv[12:2]);
        r_eid <= feidv[k*18 +: 18] ^ (rv[13] ? 18'h00000 : rv[31:14]);
        @(posedge clk);
      end
      req <= 1'b0;
      repeat (3) @(posedge clk);
      rdc(`CRX_OFS_STATUS, last_st);
    end
    // Every frame must have produced its result by now.
    `CHK("pending", 0, exq.size())
    close_out();
  end
endmodule : crx_top_tb

// ===== verilog/crx_consts.svh
// Named constants for the receive acceptance filter and its register file.
`ifndef CRX_CONSTS_SVH
`define CRX_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register map (byte offsets within the slave window)
// ----------------------------------------------------------------------------
`define CRX_ADDR_W          8
`define CRX_OFS_BUFPTR      8'h00
`define CRX_OFS_MASK_SID    8'h04
`define CRX_OFS_MASK_EID    8'h08
`define CRX_OFS_STATUS      8'h0C

// ----------------------------------------------------------------------------
// Reset values and write masks
// ----------------------------------------------------------------------------
`define CRX_RST_BUFPTR      16'h0000
`define CRX_RST_MASK_SID    16'h0000
`define CRX_RST_MASK_EID    16'h0000
`define CRX_RST_STATUS      16'h0000
`define CRX_RST_BUF         4'h0
`define CRX_RST_FLT         4'h0
`define CRX_RST_ADDR        8'h00
`define CRX_RST_HRDATA      32'h00000000
`define CRX_MASK_SID_WMASK  16'hFFEB
`define CRX_REG_PAD         16'h0000

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CRX_MSID_SID_MSB    15
`define CRX_MSID_SID_LSB    5
`define CRX_MSID_FRAME_TYPE_MATCH_MODE       3
`define CRX_MSID_EIDH_MSB   1
`define CRX_MSID_EIDH_LSB   0
`define CRX_BP_FLD_W        4
`define CRX_ST_HIT          0
`define CRX_ST_EXT          1
`define CRX_ST_BUF_MSB      7
`define CRX_ST_BUF_LSB      4
`define CRX_ST_FLT_MSB      11
`define CRX_ST_FLT_LSB      8

// ----------------------------------------------------------------------------
// Filter bank and bus encodings
// ----------------------------------------------------------------------------
`define CRX_NUM_FLT         4
`define CRX_FIRST_FLT       4'hC
`define CRX_SID_W           11
`define CRX_EID_W           18
`define CRX_HTRANS_ACT      1
`define CRX_HSIZE_WORD      3'h2
`define CRX_HRESP_OKAY      1'b0

`endif

// ===== verilog/crx_match.sv
// Masked identifier comparator for one acceptance filter.
`timescale 1ns/1ps

module crx_match
  import crx_pkg::*;
(
  // Mask settings
  input  wire crx_pkg::crx_sid_t mask_sid_i,
  input  wire crx_pkg::crx_eid_t mask_eid_i,
  input  wire logic              frame_type_match_mode_i,
  // Filter value
  input  wire logic              flt_en_i,
  input  wire crx_pkg::crx_sid_t flt_sid_i,
  input  wire crx_pkg::crx_eid_t flt_eid_i,
  input  wire logic              flt_filter_extended_frame_select_i,
  // Received frame
  input  wire crx_pkg::crx_sid_t frm_sid_i,
  input  wire crx_pkg::crx_eid_t frm_eid_i,
  input  wire logic              frm_ide_i,
  // Result
  output logic                   hit_o
);

  logic sid_ok;
  logic eid_ok;
  logic type_ok;

  // A bit only counts where its mask bit is set; clear mask bits are don't-care.
  assign sid_ok = ((frm_sid_i ^ flt_sid_i) & mask_sid_i) == '0;
  assign eid_ok = ((frm_eid_i ^ flt_eid_i) & mask_eid_i) == '0;

  // In strict mode the frame format must agree with the filter's format select.
  assign type_ok = !frame_type_match_mode_i || (frm_ide_i == flt_filter_extended_frame_select_i);

  // Standard frames carry no extended bits, so only the standard part is compared;
  // extended frames compare both parts. Format is ignored when frame_type_match_mode_i is clear.
  always_comb begin
    hit_o = 1'b0;
    if (flt_en_i && type_ok) begin
      if (frm_ide_i) begin
        hit_o = sid_ok && eid_ok;
      end else begin
        hit_o = sid_ok;
      end
    end
  end

endmodule : crx_match

// ===== verilog/crx_pkg.sv
// Types shared by the receive acceptance filter modules.
package crx_pkg;

  // --------------------------------------------------------------------------
  // Identifier and register types
  // --------------------------------------------------------------------------
  typedef logic [10:0] crx_sid_t;
  typedef logic [17:0] crx_eid_t;
  typedef logic [3:0]  crx_buf_t;
  typedef logic [15:0] crx_reg_t;

  // --------------------------------------------------------------------------
  // Bus data phase states, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CRX_BUS_IDLE = 3'b001,
    CRX_BUS_WR   = 3'b010,
    CRX_BUS_RD   = 3'b100
  } crx_bus_st_t;

endpackage : crx_pkg

// ===== verilog/crx_top.sv
// Receive acceptance mask, filter 12 to 15 routing and register slave.
//
// How it works
// - Each filter 12..15 has a 4-bit field naming the buffer for its hits.
// - Set standard mask bits compare their identifier bit; clear bits are ignored.
// - With frame-type mode set, frame format must match the filter's format select.
// - With frame-type mode clear, either format hits when masked identifiers match.
// - Two top extended mask bits sit low in the standard mask register.
// - Extended mask register holds sixteen mask bits for low extended identifier bits.
`timescale 1ns/1ps
`include "crx_consts.svh"

module crx_top (
  // Clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_i,
  // AHB-Lite slave
  input  wire logic                  hsel_i,
  input  wire logic [31:0]           haddr_i,
  input  wire logic [1:0]            htrans_i,
  input  wire logic                  hwrite_i,
  input  wire logic [2:0]            hsize_i,
  input  wire logic [31:0]           hwdata_i,
  input  wire logic                  hready_i,
  output logic                       hreadyout_o,
  output logic                       hresp_o,
  output logic [31:0]                hrdata_o,
  // Received frame from the protocol engine
  input  wire logic                  frm_valid_i,
  input  wire crx_pkg::crx_sid_t     frm_sid_i,
  input  wire crx_pkg::crx_eid_t     frm_eid_i,
  input  wire logic                  frm_ide_i,
  // Filter values 12..15, filter 12 in the lowest slice
  input  wire logic [3:0]            flt_en_i,
  input  wire logic [43:0]           flt_sid_i,
  input  wire logic [71:0]           flt_eid_i,
  input  wire logic [3:0]            flt_filter_extended_frame_select_i,
  // Acceptance result towards the message buffers
  output logic                       acc_valid_o,
  output logic                       acc_hit_o,
  output crx_pkg::crx_buf_t          acc_filter_o,
  output crx_pkg::crx_buf_t          acc_buffer_o
);

  import crx_pkg::*;

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  crx_bus_st_t st_q;
  crx_bus_st_t st_d;
  logic [`CRX_ADDR_W-1:0] addr_q;
  logic [`CRX_ADDR_W-1:0] addr_d;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  crx_reg_t bufptr_q;
  crx_reg_t bufptr_d;
  crx_reg_t mask_sid_q;
  crx_reg_t mask_sid_d;
  crx_reg_t mask_eid_q;
  crx_reg_t mask_eid_d;
  crx_reg_t status_q;
  crx_reg_t status_d;
  logic acc_valid_q;
  logic acc_valid_d;
  logic acc_hit_q;
  logic acc_hit_d;
  crx_buf_t acc_flt_q;
  crx_buf_t acc_flt_d;
  crx_buf_t acc_buf_q;
  crx_buf_t acc_buf_d;

  logic addr_phase;
  logic [`CRX_NUM_FLT-1:0] flt_hit;
  crx_buf_t flt_buf [`CRX_NUM_FLT];
  crx_sid_t eff_mask_sid;
  crx_eid_t eff_mask_eid;
  logic eff_frame_type_match_mode;

  // --------------------------------------------------------------------------
  // Mask field extraction
  // --------------------------------------------------------------------------

  // The two top extended mask bits live in the standard mask register.
  assign eff_mask_sid = mask_sid_q[`CRX_MSID_SID_MSB:`CRX_MSID_SID_LSB];
  assign eff_mask_eid = {mask_sid_q[`CRX_MSID_EIDH_MSB:`CRX_MSID_EIDH_LSB],
                         mask_eid_q};
  assign eff_frame_type_match_mode     = mask_sid_q[`CRX_MSID_FRAME_TYPE_MATCH_MODE];

  // --------------------------------------------------------------------------
  // Filter bank
  // --------------------------------------------------------------------------

  // One comparator per filter, each with its own buffer pointer field.
  for (genvar g = 0; g < `CRX_NUM_FLT; g++) begin : g_flt
    assign flt_buf[g] = bufptr_q[g*`CRX_BP_FLD_W +: `CRX_BP_FLD_W];

    crx_match u_match (
      .mask_sid_i  (eff_mask_sid),
      .mask_eid_i  (eff_mask_eid),
      .frame_type_match_mode_i      (eff_frame_type_match_mode),
      .flt_en_i    (flt_en_i[g]),
      .flt_sid_i   (flt_sid_i[g*`CRX_SID_W +: `CRX_SID_W]),
      .flt_eid_i   (flt_eid_i[g*`CRX_EID_W +: `CRX_EID_W]),
      .flt_filter_extended_frame_select_i (flt_filter_extended_frame_select_i[g]),
      .frm_sid_i   (frm_sid_i),
      .frm_eid_i   (frm_eid_i),
      .frm_ide_i   (frm_ide_i),
      .hit_o       (flt_hit[g])
    );
  end

  // --------------------------------------------------------------------------
  // Acceptance result
  // --------------------------------------------------------------------------

  // Lowest-numbered filter wins when several hit; the loop runs downward so the
  // last assignment made is that of the lowest hitting filter.
  always_comb begin
    acc_valid_d = frm_valid_i;
    acc_hit_d   = 1'b0;
    acc_flt_d   = acc_flt_q;
    acc_buf_d   = acc_buf_q;
    if (frm_valid_i) begin
      acc_flt_d = `CRX_RST_FLT;
      acc_buf_d = `CRX_RST_BUF;
      for (int i = `CRX_NUM_FLT - 1; i >= 0; i--) begin
        if (flt_hit[i]) begin
          acc_hit_d = 1'b1;
          acc_flt_d = 4'(`CRX_FIRST_FLT + 4'(i));
          acc_buf_d = flt_buf[i];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      acc_valid_q <= 1'b0;
      acc_hit_q   <= 1'b0;
      acc_flt_q   <= `CRX_RST_FLT;
      acc_buf_q   <= `CRX_RST_BUF;
    end else begin
      acc_valid_q <= acc_valid_d;
      acc_hit_q   <= acc_hit_d;
      acc_flt_q   <= acc_flt_d;
      acc_buf_q   <= acc_buf_d;
    end
  end

  // --------------------------------------------------------------------------
  // Status register
  // --------------------------------------------------------------------------

  // Records the outcome of the latest frame so software can see the routing.
  always_comb begin
    status_d = status_q;
    if (acc_valid_q) begin
      status_d = `CRX_REG_PAD;
      // The format bit was taken one cycle earlier with the frame; keep it.
      status_d[`CRX_ST_EXT] = status_q[`CRX_ST_EXT];
      status_d[`CRX_ST_HIT] = acc_hit_q;
      status_d[`CRX_ST_BUF_MSB:`CRX_ST_BUF_LSB] = acc_buf_q;
      status_d[`CRX_ST_FLT_MSB:`CRX_ST_FLT_LSB] = acc_flt_q;
    end
    if (frm_valid_i) begin
      status_d[`CRX_ST_EXT] = frm_ide_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      status_q <= `CRX_RST_STATUS;
    end else begin
      status_q <= status_d;
    end
  end

  // --------------------------------------------------------------------------
  // AHB-Lite slave
  // --------------------------------------------------------------------------

  // A transfer is taken only when selected, active and the bus is ready.
  assign addr_phase = hsel_i && htrans_i[`CRX_HTRANS_ACT] && hready_i;

  // Data phase tracking; only whole-word writes are carried out.
  always_comb begin
    st_d   = CRX_BUS_IDLE;
    addr_d = addr_q;
    if (addr_phase) begin
      addr_d = haddr_i[`CRX_ADDR_W-1:0];
      if (!hwrite_i) begin
        st_d = CRX_BUS_RD;
      end else if (hsize_i == `CRX_HSIZE_WORD) begin
        st_d = CRX_BUS_WR;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_q   <= CRX_BUS_IDLE;
      addr_q <= `CRX_RST_ADDR;
    end else begin
      st_q   <= st_d;
      addr_q <= addr_d;
    end
  end

  // Register writes land in the data phase. Unimplemented bits stay zero.
  always_comb begin
    bufptr_d   = bufptr_q;
    mask_sid_d = mask_sid_q;
    mask_eid_d = mask_eid_q;
    case (st_q)
      CRX_BUS_WR: begin
        case (addr_q)
          `CRX_OFS_BUFPTR:   bufptr_d   = hwdata_i[15:0];
          `CRX_OFS_MASK_SID: mask_sid_d = hwdata_i[15:0] & `CRX_MASK_SID_WMASK;
          `CRX_OFS_MASK_EID: mask_eid_d = hwdata_i[15:0];
          default: begin
          end
        endcase
      end
      CRX_BUS_IDLE, CRX_BUS_RD: begin
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      bufptr_q   <= `CRX_RST_BUFPTR;
      mask_sid_q <= `CRX_RST_MASK_SID;
      mask_eid_q <= `CRX_RST_MASK_EID;
    end else begin
      bufptr_q   <= bufptr_d;
      mask_sid_q <= mask_sid_d;
      mask_eid_q <= mask_eid_d;
    end
  end

  // Read data is fetched at the address phase edge from the next-state values,
  // so a read right behind a write to the same register returns the new value
  // without a wait state.
  always_comb begin
    hrdata_d = hrdata_q;
    if (addr_phase && !hwrite_i) begin
      case (haddr_i[`CRX_ADDR_W-1:0])
        `CRX_OFS_BUFPTR:   hrdata_d = {`CRX_REG_PAD, bufptr_d};
        `CRX_OFS_MASK_SID: hrdata_d = {`CRX_REG_PAD, mask_sid_d};
        `CRX_OFS_MASK_EID: hrdata_d = {`CRX_REG_PAD, mask_eid_d};
        `CRX_OFS_STATUS:   hrdata_d = {`CRX_REG_PAD, status_d};
        default:           hrdata_d = `CRX_RST_HRDATA;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_q <= `CRX_RST_HRDATA;
    end else begin
      hrdata_q <= hrdata_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------

  // The slave never stretches a transfer and never signals an error.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      hreadyout_o <= 1'b1;
      hresp_o     <= `CRX_HRESP_OKAY;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= `CRX_HRESP_OKAY;
    end
  end

  assign hrdata_o     = hrdata_q;
  assign acc_valid_o  = acc_valid_q;
  assign acc_hit_o    = acc_hit_q;
  assign acc_filter_o = acc_flt_q;
  assign acc_buffer_o = acc_buf_q;

endmodule : crx_top
